// File: design/timer_time_base_unit.sv
// Behaviour
// - Sixteen-bit auto-reload counter counting up, down or centre-aligned.
// - Prescaler divides the counter clock by 1 to 65536.
// - Prescale divisor is buffered and taken at the next update.
// - Reload moves immediately without preload, else only at update.
// - Update on overflow, underflow, or software request when not inhibited.
// - Counter advances only while enabled, starting one cycle after enable.
// - Prescaler, counter and reload registers are accessible at any time.
// - Up mode counts 0 to reload, restarts at 0, signals overflow.
// - Software update with source select set does not set the flag.
// - Update sets flag, loads prescale shadow, and reload shadow if preloaded.
// - Update inhibit blocks update events so prescale and preloaded reload shadows keep their values.
// - Update restarts prescale counter and takes the preloaded divisor; counter wraps or reloads.
// - Down mode counts reload to 0, reloads and signals underflow.
// - Centre mode counts 0 to reload-1 up, reload to 1 down.
// - Nonzero centre select forces centre mode, direction set by hardware.
// - Centre mode updates on every overflow and every underflow.
// - Generated update loads counter with 0 (reload preload in edge-aligned down mode), prescale counter with 1 (0 if divisor 0).
// - Overflow update loads reload shadow on the same edge as the counter wraps; the wrap uses the old value.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
module timer_time_base_unit
    import tbu_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                resetn,
    input  wire logic [ADDR_W-1:0]   addr,
    input  wire logic [DATA_W-1:0]   wdata,
    input  wire logic                wr_en,
    input  wire logic                rd_en,
    output logic      [DATA_W-1:0]   rdata,
    output logic                     update_irq,
    output logic                     update_event,
    output logic                     counter_tick,
    output logic                     overflow,
    output logic                     underflow
);

    logic [15:0] ctrl_ff;
    logic [15:0] psc_pre_ff;
    logic [15:0] psc_shadow;
    logic [15:0] rel_pre_ff;
    logic [15:0] rel_shadow_ff;
    logic [15:0] count_value_ff;
    logic        update_flag_ff;
    logic        irq_en_ff;
    logic        dir_down_ff;
    logic        ug_ff;
    logic        ug_src_ff;
    logic        tick;
    logic        ovf;
    logic        udf;
    logic        hw_upd;
    logic        upd;
    logic        cen;
    logic        centre;
    logic        down_mode;
    logic        at_top;
    logic        at_bot;
    cnt_state_t  state_ff;
    cnt_state_t  nxt_state;
    logic [15:0] nxt_count;
    logic [15:0] rel_eff;
    logic [15:0] psc_next;
    logic [15:0] rd_mux;
    logic        sw_upd;
    logic        wr_ctrl;
    logic        wr_stat;
    logic        wr_gen;
    logic        wr_cnt;
    logic        wr_psc;
    logic        wr_rel;
    logic        wr_ien;

    function automatic logic is_wr(input logic [3:0] a, input logic [3:0] o);
        is_wr = (a == o);
    endfunction : is_wr

    assign wr_ctrl = wr_en && is_wr(addr, CTRL_OFS);
    assign wr_stat = wr_en && is_wr(addr, STAT_OFS);
    assign wr_gen  = wr_en && is_wr(addr, EVGEN_OFS);
    assign wr_cnt  = wr_en && is_wr(addr, COUNT_OFS);
    assign wr_psc  = wr_en && is_wr(addr, PSC_OFS);
    assign wr_rel  = wr_en && is_wr(addr, RELOAD_OFS);
    assign wr_ien  = wr_en && is_wr(addr, IEN_OFS);

    assign cen       = ctrl_ff[CEN_BIT];
    assign centre    = (ctrl_ff[CAM_LSB+1:CAM_LSB] != CAM_EDGE);
    assign down_mode = centre ? dir_down_ff : ctrl_ff[DIR_BIT];

    assign rel_eff = rel_shadow_ff;

    assign at_top = centre ? (count_value_ff >= rel_eff - ONE16)
                           : (count_value_ff >= rel_eff);
    assign at_bot = centre ? (count_value_ff <= ONE16)
                           : (count_value_ff == ZERO16);

    assign ovf = tick && !down_mode && at_top;
    assign udf = tick && down_mode && at_bot;

    assign hw_upd = (ovf || udf) && !ctrl_ff[UPDATE_INHIBIT_BIT];
    assign sw_upd = ug_ff && !ctrl_ff[UPDATE_INHIBIT_BIT];
    assign upd    = hw_upd || sw_upd;
    assign psc_next = upd ? psc_pre_ff : psc_shadow;

    tbu_prescaler u_presc
    (
        .mclk    (mclk),
        .resetn  (resetn),
        .run     (cen),
        .clear   (upd),
        .divisor (psc_next),
        .tick    (tick)
    );

    tbu_reg16 u_psc_shadow
    (
        .mclk    (mclk),
        .resetn  (resetn),
        .rst_val (PSC_RST),
        .load    (upd),
        .din     (psc_pre_ff),
        .dout    (psc_shadow)
    );

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            ctrl_ff <= CTRL_RST;
        else if (wr_ctrl)
            ctrl_ff <= wdata;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            psc_pre_ff <= PSC_RST;
        else if (wr_psc)
            psc_pre_ff <= wdata;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rel_pre_ff <= RELOAD_RST;
        else if (wr_rel)
            rel_pre_ff <= wdata;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            irq_en_ff <= 1'b0;
        else if (wr_ien)
            irq_en_ff <= wdata[0];
    end

    // Update generate is a one-cycle trigger; source remembered for flag.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            ug_ff <= 1'b0;
        else
            ug_ff <= wr_gen && wdata[0];
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            ug_src_ff <= 1'b0;
        else
            ug_src_ff <= ctrl_ff[URS_BIT];
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rel_shadow_ff <= RELOAD_RST;
        else if (!ctrl_ff[ARPE_BIT])
            rel_shadow_ff <= wr_rel ? wdata : rel_pre_ff;
        else if (upd)
            rel_shadow_ff <= rel_pre_ff;
    end

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
                nxt_state = cen ? (down_mode ? ST_DOWN : ST_UP) : ST_IDLE;
            ST_UP:
                if (!cen)
                    nxt_state = ST_IDLE;
                else if (centre && ovf)
                    nxt_state = ST_DOWN;
                else if (!centre && ctrl_ff[DIR_BIT])
                    nxt_state = ST_DOWN;
            ST_DOWN:
                if (!cen)
                    nxt_state = ST_IDLE;
                else if (centre && udf)
                    nxt_state = ST_UP;
                else if (!centre && !ctrl_ff[DIR_BIT])
                    nxt_state = ST_UP;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            dir_down_ff <= 1'b0;
        else if (!centre)
            dir_down_ff <= ctrl_ff[DIR_BIT];
        else if (ovf)
            dir_down_ff <= 1'b1;
        else if (udf)
            dir_down_ff <= 1'b0;
    end

    always_comb
    begin
        nxt_count = count_value_ff;
        if (tick)
        begin
            if (!down_mode)
                nxt_count = (at_top && !centre) ? ZERO16
                          : (at_top ? rel_eff : count_value_ff + ONE16);
            else
                nxt_count = (at_bot && !centre) ? rel_eff
                          : (at_bot ? ZERO16 : count_value_ff - ONE16);
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            count_value_ff <= COUNT_RST;
        else if (wr_cnt)
            count_value_ff <= wdata;
        else if (sw_upd)
            count_value_ff <= (down_mode && !centre) ? rel_pre_ff : ZERO16;
        else
            count_value_ff <= nxt_count;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            update_flag_ff <= 1'b0;
        else if (hw_upd || (sw_upd && !ug_src_ff))
            update_flag_ff <= 1'b1;
        else if (wr_stat && !wdata[0])
            update_flag_ff <= 1'b0;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            update_irq <= 1'b0;
        else
            update_irq <= update_flag_ff && irq_en_ff;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            update_event <= 1'b0;
        else
            update_event <= upd;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            counter_tick <= 1'b0;
        else
            counter_tick <= tick;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            overflow <= 1'b0;
        else
            overflow <= ovf;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            underflow <= 1'b0;
        else
            underflow <= udf;
    end

    // Register read port.
    always_comb
    begin
        rd_mux = ZERO16;
        case (addr)
            CTRL_OFS:   rd_mux = ctrl_ff;
            STAT_OFS:   rd_mux = {15'h0000, update_flag_ff};
            COUNT_OFS:  rd_mux = count_value_ff;
            PSC_OFS:    rd_mux = psc_pre_ff;
            RELOAD_OFS: rd_mux = rel_pre_ff;
            IEN_OFS:    rd_mux = {15'h0000, irq_en_ff};
            default:    rd_mux = ZERO16;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rdata <= ZERO16;
        else if (rd_en)
            rdata <= rd_mux;
        else
            rdata <= ZERO16;
    end

endmodule : timer_time_base_unit

// File: design/tbu_pkg.sv
package tbu_pkg;

    localparam int          DATA_W = 16;
    localparam int          ADDR_W = 4;

    localparam logic [3:0]  CTRL_OFS   = 4'h0;
    localparam logic [3:0]  STAT_OFS   = 4'h1;
    localparam logic [3:0]  EVGEN_OFS  = 4'h2;
    localparam logic [3:0]  COUNT_OFS  = 4'h3;
    localparam logic [3:0]  PSC_OFS    = 4'h4;
    localparam logic [3:0]  RELOAD_OFS = 4'h5;
    localparam logic [3:0]  IEN_OFS    = 4'h6;

    localparam int          CEN_BIT    = 0;
    localparam int          UPDATE_INHIBIT_BIT  = 1;
    localparam int          URS_BIT    = 2;
    localparam int          DIR_BIT    = 4;
    localparam int          CAM_LSB    = 5;
    localparam int          ARPE_BIT   = 7;

    localparam logic [15:0] CTRL_RST   = 16'h0000;
    localparam logic [15:0] PSC_RST    = 16'h0000;
    localparam logic [15:0] RELOAD_RST = 16'hffff;
    localparam logic [15:0] COUNT_RST  = 16'h0000;
    localparam logic [15:0] ZERO16     = 16'h0000;
    localparam logic [15:0] ONE16      = 16'h0001;

    localparam logic [1:0]  CAM_EDGE   = 2'h0;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_UP   = 2'b01,
        ST_DOWN = 2'b11
    } cnt_state_t;

endpackage : tbu_pkg

// File: design/tbu_reg16.sv
module tbu_reg16
    import tbu_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic [15:0] rst_val,
    input  wire logic        load,
    input  wire logic [15:0] din,
    output logic      [15:0] dout
);

    // Holds a value loaded on request; reset value applied in a clocked way.
    logic rst_seen_ff;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rst_seen_ff <= 1'b0;
        else
            rst_seen_ff <= 1'b1;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            dout <= ZERO16;
        else if (!rst_seen_ff)
            dout <= rst_val;
        else if (load)
            dout <= din;
    end

endmodule : tbu_reg16

// File: design/tbu_prescaler.sv
module tbu_prescaler
    import tbu_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        run,
    input  wire logic        clear,
    input  wire logic [15:0] divisor,
    output logic             tick
);

    logic [15:0] pcnt_ff;

    // Prescale counter restarts on update as if a tick had just been issued.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            pcnt_ff <= ZERO16;
            tick    <= 1'b0;
        end
        else if (clear)
        begin
            pcnt_ff <= (divisor == ZERO16) ? ZERO16 : ONE16;
            tick    <= run && (divisor == ZERO16);
        end
        else if (run)
        begin
            tick <= (pcnt_ff >= divisor);
            if (pcnt_ff >= divisor)
                pcnt_ff <= ZERO16;
            else
                pcnt_ff <= pcnt_ff + ONE16;
        end
        else
            tick <= 1'b0;
    end

endmodule : tbu_prescaler

// File: sim/tbu_checker_sva.sv
module tbu_checker
(
    input wire logic                        mclk,
    input wire logic                        resetn,
    input wire logic [tbu_pkg::ADDR_W-1:0]  addr,
    input wire logic [tbu_pkg::DATA_W-1:0]  wdata,
    input wire logic                        wr_en,
    input wire logic                        rd_en,
    input wire logic [tbu_pkg::DATA_W-1:0]  rdata,
    input wire logic                        update_irq,
    input wire logic                        update_event,
    input wire logic                        counter_tick,
    input wire logic                        overflow,
    input wire logic                        underflow
);
    import tbu_pkg::*;

    logic [15:0] ctrl_ff;
    logic        ien_ff;

    // Shadow of the control register seen from the bus.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            ctrl_ff <= CTRL_RST;
        else if (wr_en && addr == CTRL_OFS)
            ctrl_ff <= wdata;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            ien_ff <= 1'b0;
        else if (wr_en && addr == IEN_OFS)
            ien_ff <= wdata[0];
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_rdata_idle: assert property (
        !rd_en |=> rdata == ZERO16)
        else $error("Read data not zero outside read");
    a_unmapped_zero: assert property (
        rd_en && addr > IEN_OFS |=> rdata == ZERO16)
        else $error("Unmapped read not zero");
    a_psc_readback: assert property (
        wr_en && addr == PSC_OFS ##2 rd_en && addr == PSC_OFS
        |=> rdata == $past(wdata, 3))
        else $error("Prescale readback wrong");
    a_reload_readback: assert property (
        wr_en && addr == RELOAD_OFS ##2 rd_en && addr == RELOAD_OFS
        |=> rdata == $past(wdata, 3))
        else $error("Reload readback wrong");
    a_halt_no_tick: assert property (
        (!ctrl_ff[CEN_BIT]) [*3]
        |-> !counter_tick && !overflow && !underflow)
        else $error("Counter moved while disabled");
    a_inhibit_no_event: assert property (
        ctrl_ff[UPDATE_INHIBIT_BIT] [*3] |-> !update_event)
        else $error("Update while inhibited");
    a_swgen_event: assert property (
        wr_en && addr == EVGEN_OFS && wdata[0] && !ctrl_ff[UPDATE_INHIBIT_BIT]
        |-> ##[1:3] update_event)
        else $error("Generated update missing");
    a_flag_irq: assert property (
        update_event && ien_ff && !ctrl_ff[URS_BIT] |-> ##[0:2] update_irq)
        else $error("Interrupt missing after update");
    a_irq_masked: assert property (
        (!ien_ff) [*3] |-> !update_irq)
        else $error("Interrupt while disabled");
endmodule : tbu_checker

bind timer_time_base_unit tbu_checker u_tbu_checker
(
    .mclk         (mclk),
    .resetn       (resetn),
    .addr         (addr),
    .wdata        (wdata),
    .wr_en        (wr_en),
    .rd_en        (rd_en),
    .rdata        (rdata),
    .update_irq   (update_irq),
    .update_event (update_event),
    .counter_tick (counter_tick),
    .overflow     (overflow),
    .underflow    (underflow)
);

// File: sim/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tbu_pkg::*;

    logic              mclk;
    logic              resetn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr_en;
    logic              rd_en;
    logic [DATA_W-1:0] rdata;
    logic              update_irq;
    logic              update_event;
    logic              counter_tick;
    logic              overflow;
    logic              underflow;
    int                num_errors;
    int                comparisons;

    timer_time_base_unit u_timer_time_base_unit (
        .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .update_irq(update_irq), .update_event(update_event),
        .counter_tick(counter_tick), .overflow(overflow),
        .underflow(underflow));

    always #2.5 mclk = ~mclk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        @(negedge mclk);
        chk(rdata, exp);
    endtask : rdchk

    // Counts cycles up to the next pulse of the chosen output.
    task automatic pulse(input int w, output int n);
        logic s;
        n = 0;
        do
        begin
            @(negedge mclk);
            n++;
            s = (w == 0) ? overflow : (w == 1) ? underflow
              : (w == 2) ? update_event : counter_tick;
        end
        while (s !== 1'b1 && n < 200);
    endtask : pulse

    task automatic period(input int w, input int exp);
        int n;
        pulse(w, n);
        pulse(w, n);
        pulse(w, n);
        chk(16'(n), 16'(exp));
    endtask : period

    task automatic t_reset;
        rdchk(CTRL_OFS, CTRL_RST);
        rdchk(PSC_OFS, PSC_RST);
        rdchk(RELOAD_OFS, RELOAD_RST);
        rdchk(COUNT_OFS, COUNT_RST);
        rdchk(STAT_OFS, ZERO16);
        wr(4'hf, 16'h1234);
        rdchk(4'hf, ZERO16);
        rdchk(EVGEN_OFS, ZERO16);
    endtask : t_reset

    task automatic t_modes;
        wr(PSC_OFS, 16'h0001);
        rdchk(PSC_OFS, 16'h0001);
        wr(RELOAD_OFS, 16'h0003);
        rdchk(RELOAD_OFS, 16'h0003);
        wr(CTRL_OFS, 16'h0001);
        period(0, 8);
        period(3, 2);
        wr(CTRL_OFS, 16'h0011);
        period(1, 8);
        wr(CTRL_OFS, 16'h0021);
        period(0, 12);
        period(1, 12);
        wr(CTRL_OFS, 16'h0071);
        period(2, 6);
        wr(CTRL_OFS, 16'h0083);
        wr(RELOAD_OFS, 16'h0005);
        period(0, 8);
        wr(CTRL_OFS, 16'h0081);
        period(0, 12);
    endtask : t_modes

    task automatic t_update;
        int n;
        wr(CTRL_OFS, 16'h0004);
        wr(STAT_OFS, ZERO16);
        wr(IEN_OFS, ONE16);
        wr(COUNT_OFS, 16'h0005);
        rdchk(COUNT_OFS, 16'h0005);
        wr(EVGEN_OFS, ONE16);
        rdchk(COUNT_OFS, ZERO16);
        rdchk(STAT_OFS, ZERO16);
        wr(CTRL_OFS, CTRL_RST);
        wr(EVGEN_OFS, ONE16);
        rdchk(STAT_OFS, ONE16);
        chk(16'(update_irq), ONE16);
        wr(STAT_OFS, ZERO16);
        rdchk(STAT_OFS, ZERO16);
        chk(16'(update_irq), ZERO16);
        wr(CTRL_OFS, 16'h0002);
        wr(EVGEN_OFS, ONE16);
        pulse(2, n);
        chk(16'(n), 16'd200);
        rdchk(STAT_OFS, ZERO16);
    endtask : t_update

    task automatic finish_test;
        $display("Comparisons %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    initial
    begin
        mclk   = 1'b0;
        resetn = 1'b0;
        addr   = '0;
        wdata  = '0;
        wr_en  = 1'b0;
        rd_en  = 1'b0;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_modes();
        t_update();
        finish_test();
    end

    initial
    begin
        #50000;
        num_errors++;
        finish_test();
    end
endmodule : tb
